/* File: hdl/scr_regs.sv */
/*
 * control and status register bank of a dual-axis sensor
 * assumes the serial command layer delivers decoded one-cycle requests
 * and that fault detectors and the thermal sensor are synchronous levels
 */
// Functional notes
// - three keyed control writes reset the logic
// - keys and reserved bits read zero
// - error-clear write clears transient errors
// - reset flag clears only after initialisation
// - bypass removes and freezes highpass filter
// - selftest direction, enable; enable freezes highpass
// - acceleration words carry selftest enable
// - invert acts only with selftest enabled
// - selftest polarity encoding per axis
// - offset correction ignores the invert bit
// - thermal register read-only signed value
// - status register readable in all modes
// - data fault cleared only by reset
// - oscillator fault forces serial output high while selected, outside test mode
// - init flag set until initialisation done
// - thermal fault clears only once condition gone
// - highpass status follows bypass setting
// - offset faults masked after reset, cleared
// - reset flag set until error-clear
// - prescaled 8-bit free-running counter
// - writes elsewhere give request error
`timescale 1ns/1ps
`include "scr_cfg.svh"
module scr_regs #(
  parameter int unsigned OFFSET_MASK_CYCLES =
    `SCR_OFFSET_MASK_MS * `SCR_CLK_MHZ * 1000,
  parameter int unsigned INIT_CYCLES        = `SCR_INIT_CYCLES
) (
  // clock and reset
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  // register request and answer
  input  wire scr_pkg::scr_req_s REQ_I,
  output scr_pkg::scr_rsp_s      RSP_O,
  // fault detectors and sensors
  input  wire logic             PARITY_FAULT_I,
  input  wire logic             FUSE_FAULT_I,
  input  wire logic             OSC_MISMATCH_I,
  input  wire logic             THERMAL_OVER_I,
  input  wire logic             OFFSET_LIMIT_X_I,
  input  wire logic             OFFSET_LIMIT_Y_I,
  input  wire logic [7:0]       THERMAL_VALUE_I,
  input  wire logic             TEST_MODE_I,
  input  wire logic             CS_ACTIVE_I,
  // dsp and serial side
  output scr_pkg::scr_dsp_s      DSP_O,
  output logic                  ACCEL_ST_FLAG_O,
  output logic                  SDO_FORCE_HIGH_O,
  output logic                  SOFT_RESET_O,
  output logic                  INIT_DONE_O
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned OSC_DIV = (`SCR_CLK_MHZ * 1000) / `SCR_OSC_KHZ;

  logic             soft_reset_reg;
  logic             int_rst;
  logic [7:0]       ctl_reg;
  logic [7:0]       wdata;
  logic             ctl_wr;
  logic             clear_err;
  scr_pkg::scr_key_e key_reg;
  logic [15:0]      init_cnt_reg;
  logic             init_reg;
  logic [31:0]      mask_cnt_reg;
  logic             mask_reg;
  logic             data_fault_reg;
  logic             fuse_stuck_reg;
  logic             thermal_reg;
  logic             off_x_reg;
  logic             off_y_reg;
  logic             reset_occ_reg;
  logic             osc_tick;
  logic [7:0]       count;
  logic [7:0]       status;
  logic [7:0]       rd_next;
  logic             st_en;
  logic             st_dir;
  logic             y_inv;
  logic             hp_byp;

  // soft reset acts as an asynchronous reset for one cycle; the key fsm,
  // the fuse latch and the answer register stay on the pin reset only
  assign int_rst   = RST_I | soft_reset_reg;
  assign wdata     = REQ_I.data;
  assign ctl_wr    = REQ_I.valid & REQ_I.write & (REQ_I.addr == `SCR_ADDR_CONTROL);
  assign clear_err = ctl_wr & wdata[`SCR_CTL_ERR_CLEAR];

  // named control fields used by the dsp decode; status reads ctl_reg directly
  assign st_en  = ctl_reg[`SCR_CTL_ST_EN];
  assign st_dir = ctl_reg[`SCR_CTL_ST_DIR];
  assign y_inv  = ctl_reg[`SCR_CTL_INVERT];
  assign hp_byp = ctl_reg[`SCR_CTL_HP_BYPASS];

  ////////////////////////////////////////////////////////////////////////////
  // keyed soft reset sequence
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      key_reg        <= scr_pkg::SCR_KEY_IDLE;
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= 1'b0;
      if (soft_reset_reg) begin
        key_reg <= scr_pkg::SCR_KEY_IDLE;
      end else if (ctl_wr) begin
        unique case (key_reg)
          scr_pkg::SCR_KEY_IDLE: begin
            if (wdata[7:6] == 2'b10) key_reg <= scr_pkg::SCR_KEY_FIRST;
          end
          scr_pkg::SCR_KEY_FIRST: begin
            // a repeated first key restarts, any other pattern aborts
            if (wdata[7:6] == 2'b11) key_reg <= scr_pkg::SCR_KEY_SECOND;
            else if (wdata[7:6] == 2'b10) key_reg <= scr_pkg::SCR_KEY_FIRST;
            else key_reg <= scr_pkg::SCR_KEY_IDLE;
          end
          scr_pkg::SCR_KEY_SECOND: begin
            // the pulse lands one cycle after the third write is taken
            if (wdata[7:6] == 2'b01) begin
              soft_reset_reg <= 1'b1;
              key_reg        <= scr_pkg::SCR_KEY_IDLE;
            end else if (wdata[7:6] == 2'b10) begin
              key_reg <= scr_pkg::SCR_KEY_FIRST;
            end else begin
              key_reg <= scr_pkg::SCR_KEY_IDLE;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: only stored bits, keys and clear read zero
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      ctl_reg <= `SCR_CTL_RESET;
    end else if (ctl_wr) begin
      ctl_reg <= wdata & `SCR_CTL_RD_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initialisation interval after any reset
  // its length is a free choice; the flag only has to stand until it ends
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      init_cnt_reg <= 16'h0000;
      init_reg     <= 1'b1;
    end else if (init_reg) begin
      init_cnt_reg <= init_cnt_reg + 16'h0001;
      if (init_cnt_reg == 16'(INIT_CYCLES - 1)) init_reg <= 1'b0;
    end
  end

  // offset fault reporting mask after reset
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      mask_cnt_reg <= 32'h0000_0000;
      mask_reg     <= 1'b1;
    end else if (mask_reg) begin
      mask_cnt_reg <= mask_cnt_reg + 32'h0000_0001;
      if (mask_cnt_reg == 32'(OFFSET_MASK_CYCLES - 1)) mask_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal data fault; fuse parity sticks through soft reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fuse_stuck_reg <= 1'b0;
    end else if (FUSE_FAULT_I && !TEST_MODE_I) begin
      fuse_stuck_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      data_fault_reg <= 1'b0;
    end else if (PARITY_FAULT_I && !TEST_MODE_I) begin
      data_fault_reg <= 1'b1;
    end
  end

  // thermal fault: set wins, clear only once condition gone
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      thermal_reg <= 1'b0;
    end else if (THERMAL_OVER_I) begin
      thermal_reg <= 1'b1;
    end else if (clear_err) begin
      thermal_reg <= 1'b0;
    end
  end

  // offset faults per axis
  // set wins over a clear written in the same cycle
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      off_x_reg <= 1'b0;
      off_y_reg <= 1'b0;
    end else begin
      if (OFFSET_LIMIT_X_I && !mask_reg) off_x_reg <= 1'b1;
      else if (clear_err) off_x_reg <= 1'b0;
      if (OFFSET_LIMIT_Y_I && !mask_reg) off_y_reg <= 1'b1;
      else if (clear_err) off_y_reg <= 1'b0;
    end
  end

  // reset-occurred: held through init, clearable afterwards
  // a clear written during initialisation is lost
  always_ff @(posedge CLK_I or posedge int_rst) begin
    if (int_rst) begin
      reset_occ_reg <= 1'b1;
    end else if (init_reg) begin
      reset_occ_reg <= 1'b1;
    end else if (clear_err) begin
      reset_occ_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter from the primary oscillator rate
  scr_tick_div #(
    .DIV (OSC_DIV)
  ) u_tick (
    .CLK_I  (CLK_I),
    .RST_I  (int_rst),
    .TICK_O (osc_tick)
  );

  scr_counter #(
    .PRE_W (5),
    .CNT_W (8)
  ) u_count (
    .CLK_I   (CLK_I),
    .RST_I   (int_rst),
    .TICK_I  (osc_tick),
    .COUNT_O (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status and read mux
  always_comb begin
    status                      = 8'h00;
    status[`SCR_ST_DATA_FAULT]  = data_fault_reg | fuse_stuck_reg;
    status[`SCR_ST_OSC_FAULT]   = OSC_MISMATCH_I;
    status[`SCR_ST_INIT]        = init_reg;
    status[`SCR_ST_THERMAL]     = thermal_reg;
    status[`SCR_ST_HP_PRESENT]  = ctl_reg[`SCR_CTL_HP_BYPASS];
    status[`SCR_ST_OFF_Y]       = off_y_reg;
    status[`SCR_ST_OFF_X]       = off_x_reg;
    status[`SCR_ST_RESET_OCC]   = reset_occ_reg;
  end

  // unmapped addresses read zero; reads are not refused, writes to them are
  always_comb begin
    unique case (REQ_I.addr)
      `SCR_ADDR_CONTROL: rd_next = ctl_reg & `SCR_CTL_RD_MASK;
      `SCR_ADDR_THERMAL: rd_next = THERMAL_VALUE_I;
      `SCR_ADDR_STATUS:  rd_next = status;
      `SCR_ADDR_COUNTER: rd_next = count;
      default:           rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RSP_O <= '0;
    end else begin
      RSP_O.valid     <= REQ_I.valid;
      RSP_O.req_error <= REQ_I.valid & REQ_I.write &
                         (REQ_I.addr != `SCR_ADDR_CONTROL);
      // a write answers with its data masked to the control register's read-back bits, at any address
      RSP_O.data      <= REQ_I.write ? (wdata & `SCR_CTL_RD_MASK) : rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dsp controls; selftest forces the bypass so the filter state freezes
  always_comb begin
    DSP_O                     = '0;
    DSP_O.st_enable           = st_en;
    DSP_O.st_direction        = st_dir;
    DSP_O.hp_bypass           = hp_byp | st_en;
    DSP_O.hp_freeze           = DSP_O.hp_bypass;
    // inversion gated by selftest; offset correction never sees it
    DSP_O.second_axis_neg     = y_inv & st_en;
    // first axis follows direction; inversion flips the second axis only
    DSP_O.first_axis_pos_def  = st_en & ~st_dir;
    DSP_O.second_axis_pos_def = st_en & (st_dir ~^ y_inv);
  end

  assign ACCEL_ST_FLAG_O  = ctl_reg[`SCR_CTL_ST_EN];
  assign SDO_FORCE_HIGH_O = OSC_MISMATCH_I & ~TEST_MODE_I & CS_ACTIVE_I;
  assign SOFT_RESET_O     = soft_reset_reg;
  assign INIT_DONE_O      = ~init_reg;

endmodule : scr_regs

/* File: hdl/scr_cfg.svh */
/*
 * constants of the sensor control and status register bank
 * assumes inclusion by bare name from design and bench files
 */
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define SCR_ADDR_CONTROL   5'h0e
`define SCR_ADDR_THERMAL   5'h0f
`define SCR_ADDR_STATUS    5'h10
`define SCR_ADDR_COUNTER   5'h11

`define SCR_CTL_KEY_HIGH   7
`define SCR_CTL_KEY_LOW    6
`define SCR_CTL_ERR_CLEAR  5
`define SCR_CTL_HP_BYPASS  3
`define SCR_CTL_INVERT     2
`define SCR_CTL_ST_DIR     1
`define SCR_CTL_ST_EN      0
`define SCR_CTL_RESET      8'h00
`define SCR_CTL_RD_MASK    8'h0f

`define SCR_ST_DATA_FAULT  7
`define SCR_ST_OSC_FAULT   6
`define SCR_ST_INIT        5
`define SCR_ST_THERMAL     4
`define SCR_ST_HP_PRESENT  3
`define SCR_ST_OFF_Y       2
`define SCR_ST_OFF_X       1
`define SCR_ST_RESET_OCC   0

`define SCR_CLK_MHZ        200
`define SCR_OSC_KHZ        4000
`define SCR_PRESCALE       32
`define SCR_OFFSET_MASK_MS 1500
`define SCR_INIT_CYCLES    64

`endif

/* File: hdl/scr_pkg.sv */
/*
 * types of the sensor control and status register bank
 * assumes scr_cfg.svh for numbers
 */
package scr_pkg;

  typedef enum logic [1:0] {
    SCR_KEY_IDLE,
    SCR_KEY_FIRST,
    SCR_KEY_SECOND
  } scr_key_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] addr;
    logic [7:0] data;
  } scr_req_s;

  typedef struct packed {
    logic       valid;
    logic       req_error;
    logic [7:0] data;
  } scr_rsp_s;

  typedef struct packed {
    logic hp_bypass;
    logic hp_freeze;
    logic st_enable;
    logic st_direction;
    logic second_axis_neg;
    logic second_axis_pos_def;
    logic first_axis_pos_def;
  } scr_dsp_s;

endpackage : scr_pkg

/* File: hdl/scr_tick_div.sv */
/*
 * divides the system clock down to one pulse per primary oscillator period
 * assumes a single synchronous clock domain
 */
`timescale 1ns/1ps
module scr_tick_div #(
  parameter int unsigned DIV = 50
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  output logic      TICK_O
);
  logic [15:0] cnt_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_reg <= 16'h0000;
      TICK_O  <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
      TICK_O  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      TICK_O  <= 1'b0;
    end
  end
endmodule : scr_tick_div

/* File: hdl/scr_counter.sv */
/*
 * prescaled free-running counter: prescaler then 8-bit wrapping count
 * assumes TICK_I pulses once per primary oscillator period
 */
`timescale 1ns/1ps
module scr_counter #(
  parameter int unsigned PRE_W = 5,
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  input  wire logic             TICK_I,
  output logic      [CNT_W-1:0] COUNT_O
);
  logic [PRE_W-1:0] pre_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_reg <= '0;
      COUNT_O <= '0;
    end else if (TICK_I) begin
      pre_reg <= pre_reg + 1'b1;
      if (pre_reg == '1) begin
        COUNT_O <= COUNT_O + 1'b1;
      end
    end
  end
endmodule : scr_counter

/* File: verif/scr_host.sv */
/* host model: issues one-cycle register requests and takes the answers
   assumes the bank answers exactly one cycle after taking a request */
`timescale 1ns/1ps
module scr_host (
  // clock
  input  wire logic              clk_i,
  // request and answer
  output scr_pkg::scr_req_s      req_o,
  input  wire scr_pkg::scr_rsp_s rsp_i
);
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                      output scr_pkg::scr_rsp_s r);
    @(posedge clk_i) #1 req_o = '{1'h1, w, a, d};
    // released lines show the inverse of the last value
    @(posedge clk_i) #1 req_o = '{1'h0, ~w, ~a, ~d};
    r = rsp_i;
  endtask : xfer
endmodule : scr_host

/* File: verif/scr_regs_checker.sv */
/* port checker of the register bank
   assumes the bank's one-cycle answer timing */
`timescale 1ns/1ps
`include "scr_cfg.svh"
module scr_regs_checker #(
  parameter int unsigned OFFSET_MASK_CYCLES = 200,
  parameter int unsigned INIT_CYCLES        = 8
) (
  input wire logic              CLK_I,
  input wire logic              RST_I,
  input wire scr_pkg::scr_req_s REQ_I,
  input wire scr_pkg::scr_rsp_s RSP_O,
  input wire logic              OSC_MISMATCH_I,
  input wire logic              TEST_MODE_I,
  input wire logic              CS_ACTIVE_I,
  input wire scr_pkg::scr_dsp_s DSP_O,
  input wire logic              ACCEL_ST_FLAG_O,
  input wire logic              SDO_FORCE_HIGH_O,
  input wire logic              SOFT_RESET_O,
  input wire logic              INIT_DONE_O
);
  localparam int INIT_SPAN = INIT_CYCLES;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_answer_next: assert property (REQ_I.valid |=> RSP_O.valid)
    else $error("answer missing");
  a_write_refused: assert property (REQ_I.valid && REQ_I.write &&
    REQ_I.addr != `SCR_ADDR_CONTROL |=> RSP_O.req_error) else $error("no refusal");
  a_write_echo: assert property (REQ_I.valid && REQ_I.write &&
    REQ_I.addr == `SCR_ADDR_CONTROL |=> !RSP_O.req_error &&
    RSP_O.data == ($past(REQ_I.data) & 8'h0f)) else $error("bad write echo");
  a_bypass_store: assert property (REQ_I.valid && REQ_I.write &&
    REQ_I.addr == `SCR_ADDR_CONTROL |=>
    DSP_O.hp_bypass == ($past(REQ_I.data[3]) || $past(REQ_I.data[0])))
    else $error("bypass not stored");
  a_polarity_code: assert property (DSP_O.st_enable |->
    DSP_O.first_axis_pos_def == !DSP_O.st_direction &&
    DSP_O.second_axis_pos_def == (DSP_O.st_direction == DSP_O.second_axis_neg))
    else $error("bad selftest polarity");
  a_force_high: assert property (SDO_FORCE_HIGH_O ==
    (OSC_MISMATCH_I && !TEST_MODE_I && CS_ACTIVE_I)) else $error("bad force");
  a_st_flag: assert property (ACCEL_ST_FLAG_O == DSP_O.st_enable)
    else $error("bad selftest flag");
  a_hp_freeze: assert property (DSP_O.hp_freeze ==
    (DSP_O.hp_bypass || DSP_O.st_enable)) else $error("bad freeze");
  a_invert_gate: assert property (DSP_O.second_axis_neg |-> DSP_O.st_enable)
    else $error("invert without selftest");
  a_soft_clear: assert property (SOFT_RESET_O |=> DSP_O == '0 &&
    !INIT_DONE_O [*4] ##[1:INIT_SPAN] INIT_DONE_O) else $error("bad soft reset");
endmodule : scr_regs_checker

bind scr_regs scr_regs_checker #(
  .OFFSET_MASK_CYCLES(OFFSET_MASK_CYCLES), .INIT_CYCLES(INIT_CYCLES)
) u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .REQ_I(REQ_I), .RSP_O(RSP_O),
  .OSC_MISMATCH_I(OSC_MISMATCH_I), .TEST_MODE_I(TEST_MODE_I), .CS_ACTIVE_I(CS_ACTIVE_I),
  .DSP_O(DSP_O), .ACCEL_ST_FLAG_O(ACCEL_ST_FLAG_O), .SDO_FORCE_HIGH_O(SDO_FORCE_HIGH_O),
  .SOFT_RESET_O(SOFT_RESET_O), .INIT_DONE_O(INIT_DONE_O)
);

/* File: verif/tb_scr_regs.sv */
/* self-checking bench of the register bank
   assumes short init and offset-mask counts set below */
`timescale 1ns/1ps
`include "scr_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_scr_regs;
  typedef struct packed {
    logic w; logic [4:0] a; logic [7:0] d; logic e; logic [7:0] x;
  } scr_row_s;
  localparam scr_row_s ROWS [11] = '{
    '{1'h0, `SCR_ADDR_CONTROL, 8'h00, 1'h0, 8'h00}, '{1'h0, `SCR_ADDR_STATUS, 8'h00, 1'h0, 8'h01},
    '{1'h1, `SCR_ADDR_CONTROL, 8'hfb, 1'h0, 8'h0b}, '{1'h0, `SCR_ADDR_CONTROL, 8'h00, 1'h0, 8'h0b},
    '{1'h0, `SCR_ADDR_STATUS, 8'h00, 1'h0, 8'h08}, '{1'h1, `SCR_ADDR_THERMAL, 8'h55, 1'h1, 8'h00},
    '{1'h1, `SCR_ADDR_STATUS, 8'h55, 1'h1, 8'h00}, '{1'h1, `SCR_ADDR_COUNTER, 8'h55, 1'h1, 8'h00},
    '{1'h0, `SCR_ADDR_THERMAL, 8'h00, 1'h0, 8'h9c}, '{1'h1, `SCR_ADDR_CONTROL, 8'h00, 1'h0, 8'h00},
    '{1'h0, `SCR_ADDR_STATUS, 8'h00, 1'h0, 8'h00}};
  localparam logic [7:0] STD [6] = '{8'h07, 8'h03, 8'h04, 8'h01, 8'h05, 8'h08};
  localparam logic [6:0] STX [6] = '{7'h7e, 7'h78, 7'h00, 7'h73, 7'h75, 7'h60};
  logic clk = 1'h0, rst = 1'h1, pf, ff, osc, tov, ox, oy, tm, cs, stf, sdo, srst, idone;
  logic [7:0] tv, c0;
  scr_pkg::scr_req_s req;
  scr_pkg::scr_rsp_s rsp, r;
  scr_pkg::scr_dsp_s dsp;
  int err_count = 0, checked = 0, n_srst = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (srst === 1'h1) n_srst++;
  scr_host host (.clk_i(clk), .req_o(req), .rsp_i(rsp));
  scr_regs #(.OFFSET_MASK_CYCLES(200), .INIT_CYCLES(8)) dut (
    .CLK_I(clk), .RST_I(rst), .REQ_I(req), .RSP_O(rsp), .PARITY_FAULT_I(pf),
    .FUSE_FAULT_I(ff), .OSC_MISMATCH_I(osc), .THERMAL_OVER_I(tov), .OFFSET_LIMIT_X_I(ox),
    .OFFSET_LIMIT_Y_I(oy), .THERMAL_VALUE_I(tv), .TEST_MODE_I(tm), .CS_ACTIVE_I(cs),
    .DSP_O(dsp), .ACCEL_ST_FLAG_O(stf), .SDO_FORCE_HIGH_O(sdo), .SOFT_RESET_O(srst),
    .INIT_DONE_O(idone));
  task automatic t(input logic w, input logic [4:0] a, input logic [7:0] d, x, m);
    host.xfer(w, a, d, r);
    `CHK(r.data & m, x)
  endtask : t
  task automatic wait_init();
    for (int k = 0; k < 100 && idone !== 1'h1; k++) @(posedge clk);
    #1;
  endtask : wait_init
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    {pf, ff, osc, tov, ox, oy, tm, cs} = 8'h00;
    tv = 8'h9c;
    repeat (6) @(posedge clk);
    `CHK(rsp, '0)
    #1 rst = 1'h0;
    wait_init();
    foreach (ROWS[i]) begin
      host.xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d, r);
      `CHK(r.req_error, ROWS[i].e)
      if (!ROWS[i].e) `CHK(r.data, ROWS[i].x)
    end
    foreach (STD[i]) begin
      t(1'h1, `SCR_ADDR_CONTROL, STD[i], STD[i], 8'hff);
      `CHK(dsp, STX[i])
      `CHK(stf, STD[i][0])
    end
    t(1'h1, `SCR_ADDR_CONTROL, 8'h00, 8'h00, 8'hff);
    {ox, oy} = 2'h3;
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h00, 8'hff);
    repeat (250) @(posedge clk);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h06, 8'hff);
    #1 {ox, oy} = 2'h0;
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h00, 8'hff);
    #1 tov = 1'h1;
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h10, 8'hff);
    #1 tov = 1'h0;
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h00, 8'hff);
    #1 {osc, cs} = 2'h3;
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h40, 8'h40);
    `CHK(sdo, 1'h1)
    #1 tm = 1'h1;
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h40, 8'h40);
    `CHK(sdo, 1'h0)
    #1 {osc, cs, tm} = 3'h0;
    #1 pf = 1'h1;
    @(posedge clk) #1 pf = 1'h0;
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h80, 8'hff);
    t(1'h0, `SCR_ADDR_COUNTER, 8'h00, 8'h00, 8'h00);
    c0 = r.data;
    repeat (1598) @(posedge clk);
    t(1'h0, `SCR_ADDR_COUNTER, 8'h00, 8'h00, 8'h00);
    `CHK(r.data - c0, 8'h01)
    // host aborts with a both-keys-clear write
    t(1'h1, `SCR_ADDR_CONTROL, 8'h80, 8'h00, 8'hff);
    t(1'h1, `SCR_ADDR_CONTROL, 8'h01, 8'h01, 8'hff);
    t(1'h1, `SCR_ADDR_CONTROL, 8'h40, 8'h00, 8'hff);
    `CHK(n_srst, 0)
    t(1'h1, `SCR_ADDR_CONTROL, 8'h8b, 8'h0b, 8'hff);
    t(1'h1, `SCR_ADDR_CONTROL, 8'hc0, 8'h00, 8'hff);
    t(1'h1, `SCR_ADDR_CONTROL, 8'h40, 8'h00, 8'hff);
    repeat (2) @(posedge clk);
    `CHK(n_srst, 1)
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h21, 8'hff);
    wait_init();
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h01, 8'hff);
    t(1'h1, `SCR_ADDR_CONTROL, 8'h20, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_STATUS, 8'h00, 8'h00, 8'hff);
    t(1'h0, `SCR_ADDR_CONTROL, 8'h00, 8'h00, 8'hff);
    finish_test();
  end
endmodule : tb_scr_regs
